// File: design/gpio_cfg.svh
// Constants for the processor GPIO banks: addresses, offsets, resets, sizes
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// Bank windows, 4 KB each
`define GPIO_BANK0_BASE   32'hff208000
`define GPIO_BANK1_BASE   32'hff209000
`define GPIO_BANK2_BASE   32'hff20a000
`define GPIO_WIN_BITS     12

// Register offsets inside a bank window
`define GPIO_OFS_LEVEL    12'h000
`define GPIO_OFS_DIR      12'h004
`define GPIO_OFS_SAMPLE   12'h050
`define GPIO_OFS_INP      12'h054

// Reset values: all lines inputs, output levels low
`define GPIO_LEVEL_RESET  32'h00000000
`define GPIO_DIR_RESET    32'h00000000

// Lines per bank
`define GPIO_BANK0_LINES  29
`define GPIO_BANK1_LINES  29
`define GPIO_BANK2_LINES  13
`define GPIO_INP_LINES    14

`endif

// File: design/gpio_pkg.sv
// Types and decode helpers shared by the GPIO bank logic
package gpio_pkg;
  `include "gpio_cfg.svh"

  typedef enum {
    SEL_NONE,
    SEL_LEVEL,
    SEL_DIR,
    SEL_SAMPLE,
    SEL_INP
  } reg_sel_t;

  // Map a window offset to the register it names
  function automatic reg_sel_t decode_offset(
    input logic [`GPIO_WIN_BITS-1:0] ofs);
    case (ofs)
      `GPIO_OFS_LEVEL:  decode_offset = SEL_LEVEL;
      `GPIO_OFS_DIR:    decode_offset = SEL_DIR;
      `GPIO_OFS_SAMPLE: decode_offset = SEL_SAMPLE;
      `GPIO_OFS_INP:    decode_offset = SEL_INP;
      default:          decode_offset = SEL_NONE;
    endcase
  endfunction

  // True when an address falls inside the 4 KB window at base
  function automatic logic in_window(input logic [31:0] addr,
                                     input logic [31:0] base);
    in_window = (addr[31:`GPIO_WIN_BITS] == base[31:`GPIO_WIN_BITS]);
  endfunction
endpackage

// File: design/gpio_bank_if.sv
// Register access carrier between the decoder and one GPIO bank
`timescale 1ns/10ps
`include "gpio_cfg.svh"
interface gpio_bank_if;
  import gpio_pkg::*;
  logic                      sel;
  logic                      wr;
  logic [`GPIO_WIN_BITS-1:0] offset;
  logic [31:0]               wdata;
  logic [31:0]               rdata;

  modport bank (input sel, input wr, input offset, input wdata,
                output rdata);
  modport ctrl (output sel, output wr, output offset, output wdata,
                input rdata);
endinterface

// File: design/gpio_bank.sv
// One GPIO bank: direction, output level and synchronised input sample
`timescale 1ns/10ps
`include "gpio_cfg.svh"
module gpio_bank
  import gpio_pkg::*;
#(
  parameter int unsigned LINES = 29
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  // Register access
  gpio_bank_if.bank             bus,
  // Pins
  input  wire logic [LINES-1:0] pin_in_i,
  output logic      [LINES-1:0] pin_out_o,
  output logic      [LINES-1:0] pin_oe_o
);

  localparam logic [31:0] LINE_MASK = 32'((64'h1 << LINES) - 64'h1);

  typedef struct packed {
    logic [31:0] level;
    logic [31:0] dir;
    logic [31:0] meta;
    logic [31:0] sync;
  } bank_state_t;

  bank_state_t      st_reg;
  bank_state_t      st_next;
  reg_sel_t         sel;
  logic [LINES-1:0] wdata_lines;

  assign sel         = decode_offset(bus.offset);
  assign wdata_lines = bus.wdata[LINES-1:0];

  // Next state: two-stage pin sampling and register writes
  always_comb
  begin
    st_next      = st_reg;
    st_next.meta = 32'(pin_in_i);
    st_next.sync = st_reg.meta;
    if (bus.sel && bus.wr)
    begin
      case (sel)
        SEL_LEVEL: st_next.level = bus.wdata & LINE_MASK;
        SEL_DIR:   st_next.dir   = bus.wdata & LINE_MASK;
        default:   st_next       = st_next;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '{level: `GPIO_LEVEL_RESET, dir: `GPIO_DIR_RESET,
                  meta: 32'h0, sync: 32'h0};
    else
      st_reg <= st_next;
  end

  // Read mux; bits above the top line stay zero
  always_comb
  begin
    case (sel)
      SEL_LEVEL:  bus.rdata = st_reg.level;
      SEL_DIR:    bus.rdata = st_reg.dir;
      SEL_SAMPLE: bus.rdata = st_reg.sync & LINE_MASK;
      default:    bus.rdata = 32'h0;
    endcase
  end

  // Driver enable follows direction, level follows output register
  assign pin_oe_o  = st_reg.dir[LINES-1:0];
  assign pin_out_o = st_reg.level[LINES-1:0];

  a_dir_sets_oe:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus.sel && bus.wr && sel == SEL_DIR) |=>
      (pin_oe_o == $past(wdata_lines)))
  else $error("Direction write did not reach the driver enables");

  a_level_sets_out:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus.sel && bus.wr && sel == SEL_LEVEL) |=>
      (pin_out_o == $past(wdata_lines)))
  else $error("Level write did not reach the pin outputs");

  a_sample_reads_pins:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus.sel && !bus.wr && sel == SEL_SAMPLE) |->
      (bus.rdata[LINES-1:0] == $past(pin_in_i, 2)))
  else $error("Sample read does not show the pin levels");

  a_upper_bits_zero:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus.rdata & ~LINE_MASK) == 32'h0)
  else $error("Bits above the top line read nonzero");

  a_dir_readback:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus.sel && !bus.wr && sel == SEL_DIR) |->
      (bus.rdata[LINES-1:0] == pin_oe_o))
  else $error("Direction readback differs from driver enables");

endmodule

// File: design/processor_gpio_banks.sv
// Processor GPIO: three banks of bidirectional lines plus input-only lines
//
// Summary of operation
// - First bank drives and samples lines 0 through 28.
// - Second bank serves lines 29 through 57; bit 0 is line 29.
// - Third bank serves lines 58-70 plus fourteen input-only lines.
// - Each bank has direction, output level and input sample registers.
// - Direction bit n governs the bank's n-th line, LSB first line.
// - Direction 1 enables the driver; 0 releases it as input.
// - Output level bit n sets the driven level, 1 high, 0 low.
// - Input sample bit n reads the level of the bank's n-th line from two clocks earlier.
// - Third bank decodes in the 4 KB window at 0xFF20A000.
// - Second bank window base conflict resolved to 0xFF209000.
// - Second bank bit 24 is line 53, bit 25 is line 54.
`timescale 1ns/10ps
`include "gpio_cfg.svh"
module processor_gpio_banks
  import gpio_pkg::*;
#(
  parameter int unsigned BANK0_LINES = `GPIO_BANK0_LINES,
  parameter int unsigned BANK1_LINES = `GPIO_BANK1_LINES,
  parameter int unsigned BANK2_LINES = `GPIO_BANK2_LINES,
  parameter int unsigned INP_LINES   = `GPIO_INP_LINES,
  localparam int unsigned TOTAL = BANK0_LINES + BANK1_LINES + BANK2_LINES
) (
  // Clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // Memory-mapped register port
  input  wire logic [31:0]          bus_addr_i,
  input  wire logic                 bus_wr_i,
  input  wire logic                 bus_rd_i,
  input  wire logic [31:0]          bus_wdata_i,
  output logic      [31:0]          bus_rdata_o,
  output logic                      bus_ack_o,
  output logic                      bus_err_o,
  // Bidirectional lines, split into input, output and enable
  input  wire logic [TOTAL-1:0]     gpio_in_i,
  output logic      [TOTAL-1:0]     gpio_out_o,
  output logic      [TOTAL-1:0]     gpio_oe_o,
  // Input-only lines
  input  wire logic [INP_LINES-1:0] inp_only_i
);

  localparam int unsigned NUM_BANKS = 3;

  typedef struct packed {
    logic [31:0]          rdata;
    logic                 ack;
    logic                 err;
    logic [INP_LINES-1:0] inp_meta;
    logic [INP_LINES-1:0] inp_sync;
  } top_state_t;

  // Window base of each bank
  function automatic logic [31:0] bank_base(input int unsigned b);
    case (b)
      0:       bank_base = `GPIO_BANK0_BASE;
      1:       bank_base = `GPIO_BANK1_BASE;
      default: bank_base = `GPIO_BANK2_BASE;
    endcase
  endfunction

  // Number of lines owned by each bank
  function automatic int unsigned bank_lines(input int unsigned b);
    case (b)
      0:       bank_lines = BANK0_LINES;
      1:       bank_lines = BANK1_LINES;
      default: bank_lines = BANK2_LINES;
    endcase
  endfunction

  // First global line number of each bank
  function automatic int unsigned line_base(input int unsigned b);
    case (b)
      0:       line_base = 0;
      1:       line_base = BANK0_LINES;
      default: line_base = BANK0_LINES + BANK1_LINES;
    endcase
  endfunction

  top_state_t             st_reg;
  top_state_t             st_next;
  logic                   req;
  logic [NUM_BANKS-1:0]   bank_hit;
  logic                   any_hit;
  logic [31:0]            bank_rdata [NUM_BANKS];
  logic [31:0]            read_mux;
  reg_sel_t               req_sel;

  // A request is either a read or a write strobe; a write wins if both
  assign req     = bus_wr_i | bus_rd_i;
  assign req_sel = decode_offset(bus_addr_i[`GPIO_WIN_BITS-1:0]);
  assign any_hit = |bank_hit;

  // Window decode, one select per bank
  always_comb
  begin
    for (int unsigned b = 0; b < NUM_BANKS; b++)
      bank_hit[b] = req && in_window(bus_addr_i, bank_base(b));
  end

  // Bank instances, each wired to its own slice of the lines
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    localparam int unsigned BASE = line_base(b);
    localparam int unsigned W    = bank_lines(b);

    gpio_bank_if bif ();

    assign bif.sel    = bank_hit[b];
    assign bif.wr     = bus_wr_i;
    assign bif.offset = bus_addr_i[`GPIO_WIN_BITS-1:0];
    assign bif.wdata  = bus_wdata_i;
    assign bank_rdata[b] = bif.rdata;

    // Bank b owns lines BASE upward; its bit 0 is line BASE
    gpio_bank #(
      .LINES (W)
    ) u_bank (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .bus       (bif.bank),
      .pin_in_i  (gpio_in_i[BASE +: W]),
      .pin_out_o (gpio_out_o[BASE +: W]),
      .pin_oe_o  (gpio_oe_o[BASE +: W])
    );
  end

  // Read data: selected bank, plus input-only lines in the third bank
  always_comb
  begin
    read_mux = 32'h0;
    for (int unsigned b = 0; b < NUM_BANKS; b++)
    begin
      if (bank_hit[b])
        read_mux = read_mux | bank_rdata[b];
    end
    if (bank_hit[NUM_BANKS-1] && req_sel == SEL_INP)
      read_mux = 32'(st_reg.inp_sync);
  end

  // Next state: answer strobes, read capture, input-only synchroniser
  always_comb
  begin
    st_next          = st_reg;
    st_next.inp_meta = inp_only_i;
    st_next.inp_sync = st_reg.inp_meta;
    st_next.ack      = req && any_hit;
    st_next.err      = req && !any_hit;
    st_next.rdata    = (bus_rd_i && !bus_wr_i && any_hit) ? read_mux
                                                          : 32'h0;
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '{rdata: 32'h0, ack: 1'b0, err: 1'b0,
                  inp_meta: '0, inp_sync: '0};
    else
      st_reg <= st_next;
  end

  // Outputs straight from flip-flops
  assign bus_rdata_o = st_reg.rdata;
  assign bus_ack_o   = st_reg.ack;
  assign bus_err_o   = st_reg.err;

  // Helper wires for the checks below
  logic        wr_bank0_level;
  logic        wr_bank1_level;
  logic        wr_bank1_dir;
  logic        wr_bank2_dir;
  logic        ctrl_wr;
  logic        rd_only;
  logic        rd_inp;
  logic        rd_inp_low;
  logic [1:0]  led_btn_bits;
  logic [12:0] low_wdata;

  assign wr_bank0_level = bus_wr_i && bank_hit[0] && req_sel == SEL_LEVEL;
  assign wr_bank1_level = bus_wr_i && bank_hit[1] && req_sel == SEL_LEVEL;
  assign wr_bank1_dir   = bus_wr_i && bank_hit[1] && req_sel == SEL_DIR;
  assign wr_bank2_dir   = bus_wr_i && bank_hit[2] && req_sel == SEL_DIR;
  assign ctrl_wr        = bus_wr_i && any_hit &&
                          (req_sel == SEL_LEVEL || req_sel == SEL_DIR);
  assign rd_only        = bus_rd_i && !bus_wr_i;
  assign rd_inp         = rd_only && bank_hit[2] && req_sel == SEL_INP;
  assign rd_inp_low     = rd_only && (bank_hit[0] || bank_hit[1]) &&
                          req_sel == SEL_INP;
  assign led_btn_bits   = bus_wdata_i[25:24];
  assign low_wdata      = bus_wdata_i[12:0];

  a_ack_next_cycle:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req && any_hit) |=> (bus_ack_o && !bus_err_o))
  else $error("Mapped access was not acknowledged one cycle later");

  a_err_unmapped:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req && !any_hit) |=> (bus_err_o && !bus_ack_o && bus_rdata_o == 0))
  else $error("Unmapped access was not flagged");

  a_led_button_map:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_bank1_dir |=> (gpio_oe_o[54:53] == $past(led_btn_bits)))
  else $error("Second bank bits 24 and 25 do not steer lines 53 and 54");

  a_third_window:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_bank2_dir |=> (gpio_oe_o[70:58] == $past(low_wdata)))
  else $error("Third bank window does not steer lines 58 to 70");

  a_inp_readback:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_inp |=> (bus_rdata_o == 32'($past(inp_only_i, 3))))
  else $error("Input-only read does not show the synchronised lines");

  a_single_window:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $onehot0(bank_hit))
  else $error("Address hit more than one bank window");

  a_bank0_lines:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_bank0_level |=> (gpio_out_o[28:0] == $past(bus_wdata_i[28:0])))
  else $error("First bank level write did not reach lines 0 to 28");

  a_bank1_lines:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_bank1_level |=> (gpio_out_o[57:29] == $past(bus_wdata_i[28:0])))
  else $error("Second bank bit 0 does not land on line 29");

  a_inp_other_banks:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_inp_low |=> (bus_ack_o && bus_rdata_o == 32'h0))
  else $error("Input-only offset read nonzero outside the third bank");

  a_inp_width:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_inp |=> (bus_rdata_o[31:14] == 18'h0))
  else $error("Input-only read shows bits above line 13");

  a_rdata_idle_zero:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !bus_ack_o |-> (bus_rdata_o == 32'h0))
  else $error("Read data nonzero outside an acknowledge cycle");

  a_dir_first_line:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_bank1_dir |=> (gpio_oe_o[29] == $past(bus_wdata_i[0])))
  else $error("Direction bit 0 does not steer the first line of the bank");

  a_oe_held:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ctrl_wr |=> $stable(gpio_oe_o))
  else $error("Driver enables moved without a control write");

  a_level_keeps_dir:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus_wr_i && any_hit && req_sel == SEL_LEVEL) |=> $stable(gpio_oe_o))
  else $error("Level write disturbed the driver enables");

  a_out_held:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !ctrl_wr |=> $stable(gpio_out_o))
  else $error("Pin levels moved without a control write");

  a_dir_keeps_level:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (bus_wr_i && any_hit && req_sel == SEL_DIR) |=> $stable(gpio_out_o))
  else $error("Direction write disturbed the pin levels");

  a_window_first:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req && bus_addr_i[31:12] == 20'hff208) |-> bank_hit[0])
  else $error("First bank window missed its own address");

  a_window_second:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req && bus_addr_i[31:12] == 20'hff209) |-> bank_hit[1])
  else $error("Second bank window missed its own address");

  a_window_third:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (req && bus_addr_i[31:12] == 20'hff20a) |-> bank_hit[2])
  else $error("Third bank window missed its own address");

  a_led_level:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_bank1_level |=> (gpio_out_o[53] == $past(bus_wdata_i[24])))
  else $error("Second bank level bit 24 does not drive line 53");

  a_rdata_top_zero:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bus_rdata_o[31:29] == 3'h0)
  else $error("Read data shows bits above every bank's top line");

  a_write_reads_zero:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bus_wr_i |=> (bus_rdata_o == 32'h0))
  else $error("Write answered with nonzero read data");

  a_ack_err_apart:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(bus_ack_o && bus_err_o))
  else $error("Acknowledge and error raised together");

  a_idle_no_answer:
  assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !req |=> (!bus_ack_o && !bus_err_o))
  else $error("Answer raised without a request");

endmodule

// File: verification/board_pin_loads.sv
// Board loads on the GPIO lines: lamp, push-button and far-end levels
`timescale 1ns/10ps
module board_pin_loads (
  // Device pin side
  input  wire logic [70:0] gpio_out_i,
  input  wire logic [70:0] gpio_oe_i,
  // Far-end levels and button
  input  wire logic [70:0] ext_level_i,
  input  wire logic        btn_press_i,
  output logic      [70:0] gpio_in_o,
  output logic             lamp_on_o
);
  // Wire level: an enabled driver wins, else the far end sets it, or the button on line 54
  always_comb
  begin
    gpio_in_o = ext_level_i;
    gpio_in_o[54] = ~btn_press_i;
    for (int i = 0; i < 71; i++)
    begin
      if (gpio_oe_i[i])
        gpio_in_o[i] = gpio_out_i[i];
    end
  end

  // Lamp lights on a high level of its line
  assign lamp_on_o = gpio_in_o[53];
endmodule

// File: verification/test_processor_gpio_banks.sv
// Self-checking bench for the processor GPIO banks
`timescale 1ns/10ps
`include "gpio_cfg.svh"
module test_processor_gpio_banks;
  import gpio_pkg::*;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic [31:0] bus_addr_i;
  logic        bus_wr_i;
  logic        bus_rd_i;
  logic [31:0] bus_wdata_i;
  logic [31:0] bus_rdata_o;
  logic        bus_ack_o;
  logic        bus_err_o;
  logic [70:0] gpio_in_i;
  logic [70:0] gpio_out_o;
  logic [70:0] gpio_oe_o;
  logic [13:0] inp_only_i;
  logic [70:0] ext_level;
  logic        btn_press;
  logic        lamp_on;
  int          errors;
  int          cmp_count;
  logic [31:0] rnd;
  logic [31:0] dat;
  int          b;
  logic [31:0] lvl_m [3];
  logic [31:0] dir_m [3];
  logic [31:0] bases [3] = '{`GPIO_BANK0_BASE, `GPIO_BANK1_BASE,
                             `GPIO_BANK2_BASE};
  logic [31:0] masks [3] = '{32'h1fffffff, 32'h1fffffff, 32'h00001fff};
  logic [31:0] bad   [4] = '{32'hff207ffc, 32'hff20b000, 32'h00000000,
                             32'hfe209004};

  processor_gpio_banks u_processor_gpio_banks (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .bus_addr_i  (bus_addr_i),
    .bus_wr_i    (bus_wr_i),
    .bus_rd_i    (bus_rd_i),
    .bus_wdata_i (bus_wdata_i),
    .bus_rdata_o (bus_rdata_o),
    .bus_ack_o   (bus_ack_o),
    .bus_err_o   (bus_err_o),
    .gpio_in_i   (gpio_in_i),
    .gpio_out_o  (gpio_out_o),
    .gpio_oe_o   (gpio_oe_o),
    .inp_only_i  (inp_only_i)
  );

  board_pin_loads u_board_pin_loads (
    .gpio_out_i  (gpio_out_o),
    .gpio_oe_i   (gpio_oe_o),
    .ext_level_i (ext_level),
    .btn_press_i (btn_press),
    .gpio_in_o   (gpio_in_i),
    .lamp_on_o   (lamp_on)
  );

  // 200 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    print_verdict();
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Line vector from per-bank register images
  function automatic logic [70:0] full(input logic [31:0] v [3]);
    return {v[2][12:0], v[1][28:0], v[0][28:0]};
  endfunction

  // Expected line levels and bank sample image
  function automatic logic [31:0] samp(input int bk);
    logic [70:0] p;
    p = ext_level;
    p[54] = ~btn_press;
    p = (full(dir_m) & full(lvl_m)) | (~full(dir_m) & p);
    case (bk)
      0: return {3'h0, p[28:0]};
      1: return {3'h0, p[57:29]};
      default: return {19'h0, p[70:58]};
    endcase
  endfunction

  task automatic check(input logic [143:0] seen, input logic [143:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h",
               $time, seen, exp);
    end
  endtask

  // One strobed access; answer is settled when the task returns
  task automatic access(input logic wr, input logic [31:0] addr,
                        input logic [31:0] data);
    @(posedge clk_sys_i);
    #1;
    bus_wr_i    = wr;
    bus_rd_i    = ~wr;
    bus_addr_i  = addr;
    bus_wdata_i = data;
    @(posedge clk_sys_i);
    #1;
    bus_wr_i = 1'b0;
    bus_rd_i = 1'b0;
  endtask

  task automatic wr_reg(input int bk, input logic [11:0] ofs,
                        input logic [31:0] data);
    access(1'b1, bases[bk] + ofs, data);
    if (ofs == `GPIO_OFS_LEVEL)
      lvl_m[bk] = data & masks[bk];
    if (ofs == `GPIO_OFS_DIR)
      dir_m[bk] = data & masks[bk];
    check({bus_ack_o, bus_err_o}, 2'b10);
    check(gpio_oe_o, full(dir_m));
    check(gpio_out_o, full(lvl_m));
  endtask

  task automatic rd_reg(input int bk, input logic [11:0] ofs,
                        input logic [31:0] exp);
    access(1'b0, bases[bk] + ofs, 32'h0);
    check({bus_ack_o, bus_rdata_o}, {1'b1, exp});
  endtask

  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    errors = 0;
    cmp_count = 0;
    rnd = 32'ha096;
    rst_n_i = 1'b0;
    {bus_wr_i, bus_rd_i, btn_press} = 3'h0;
    bus_addr_i = 32'h0;
    bus_wdata_i = 32'h0;
    ext_level = 71'h0;
    inp_only_i = 14'h0;
    for (int i = 0; i < 3; i++)
    begin
      lvl_m[i] = `GPIO_LEVEL_RESET;
      dir_m[i] = `GPIO_DIR_RESET;
    end
    repeat (2) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    // Reset state
    check({gpio_oe_o, gpio_out_o}, 142'h0);
    for (int i = 0; i < 3; i++)
    begin
      rd_reg(i, `GPIO_OFS_DIR, `GPIO_DIR_RESET);
      rd_reg(i, `GPIO_OFS_LEVEL, `GPIO_LEVEL_RESET);
    end
    // Random traffic with all-ones and zero corners
    for (int i = 0; i < 60; i++)
    begin
      rnd = xs(rnd);
      b = rnd % 3;
      dat = (i < 3) ? 32'hffffffff : (i < 6) ? 32'h0 : xs(rnd);
      wr_reg(b, `GPIO_OFS_DIR, dat ^ rnd);
      wr_reg(b, `GPIO_OFS_LEVEL, dat);
      rnd = xs(rnd);
      ext_level = {rnd[6:0], xs(rnd), rnd};
      inp_only_i = rnd[31:18];
      btn_press = rnd[3];
      repeat (3) @(posedge clk_sys_i);
      rd_reg(b, `GPIO_OFS_DIR, dir_m[b]);
      rd_reg(b, `GPIO_OFS_LEVEL, lvl_m[b]);
      rd_reg(b, `GPIO_OFS_SAMPLE, samp(b));
      rd_reg(b, `GPIO_OFS_INP, (b == 2) ? 32'(inp_only_i) : 32'h0);
    end
    // Lamp and button lines of the second bank
    wr_reg(1, `GPIO_OFS_DIR, 32'h01000000);
    wr_reg(1, `GPIO_OFS_LEVEL, 32'h01000000);
    check(lamp_on, 1'b1);
    btn_press = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd_reg(1, `GPIO_OFS_SAMPLE, samp(1));
    check(bus_rdata_o[25], 1'b0);
    // Outside every window and unknown offsets inside one
    for (int i = 0; i < 4; i++)
    begin
      access(1'b1, bad[i], 32'hffffffff);
      check({bus_ack_o, bus_err_o, gpio_oe_o}, {2'b01, full(dir_m)});
      access(1'b0, bad[i], 32'h0);
      check({bus_err_o, bus_rdata_o}, {1'b1, 32'h0});
    end
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(i, `GPIO_OFS_SAMPLE, 32'hffffffff);
      wr_reg(i, 12'h008, 32'hffffffff);
      rd_reg(i, 12'h008, 32'h0);
    end
    print_verdict();
  end
endmodule
